// *** hrc_pkg.sv ***
// Purpose: shared constants and types for the host remote command parser
// Assumes: byte stream from the usb data interface arrives one byte per valid strobe
// Notes:   key indices are the codes presented to the keypad logic
package hrc_pkg;
   localparam logic [7:0] ESC_BYTE   = 8'h1B;
   localparam logic [7:0] CR_BYTE    = 8'h0D;
   localparam logic [7:0] CTRL_B     = 8'h02;
   localparam logic [7:0] CTRL_P     = 8'h10;
   localparam logic [7:0] CLASS_KEY  = 8'h54; // 'T'
   localparam logic [7:0] CLASS_OUT  = 8'h41; // 'A'
   localparam logic [7:0] CLASS_SPC  = 8'h53; // 'S'
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_NINE = 8'h39;
   localparam int         CODE_DIGITS = 4;

   // virtual key indices
   localparam logic [4:0] KEY_DIGIT0  = 5'h00; // digits 0..9 are 0x00..0x09
   localparam logic [4:0] KEY_CLEAR   = 5'h0A;
   localparam logic [4:0] KEY_SIGN    = 5'h0B;
   localparam logic [4:0] KEY_DOT     = 5'h0C;
   localparam logic [4:0] KEY_ENTER   = 5'h0D;
   localparam logic [4:0] KEY_AXIS1   = 5'h0E; // axis 1..3 follow
   localparam logic [4:0] KEY_SOFT1   = 5'h11; // soft 1..4 follow
   localparam logic [4:0] KEY_LEFT    = 5'h15;
   localparam logic [4:0] KEY_RIGHT   = 5'h16;
   localparam logic [4:0] KEY_UP      = 5'h17;
   localparam logic [4:0] KEY_DOWN    = 5'h18;

   // codes as a 14-bit binary value of the four decimal digits
   localparam logic [13:0] CODE_ID     = 14'h0000;
   localparam logic [13:0] CODE_POS    = 14'h00C8; // 200
   localparam logic [13:0] CODE_RESET  = 14'h0000;
   localparam logic [13:0] CODE_LOCK   = 14'h0001;
   localparam logic [13:0] CODE_UNLOCK = 14'h0002;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hrc_byte_t;

   typedef struct packed {
      logic       key_press;
      logic [4:0] key_code;
      logic       send_ident;
      logic       send_position;
      logic       send_screen;
      logic       device_reset;
   } hrc_cmd_t;
endpackage : hrc_pkg

// *** hrc_key_decode.sv ***
// Purpose: map a key-class frame code onto a virtual key index
// Assumes: code is the binary value of the four decimal digits
// Notes:   purely combinational; unassigned codes give hit low
`timescale 1ns/100ps
module hrc_key_decode
   import hrc_pkg::*;
(
   input  wire logic [13:0] code,
   output logic             hit,
   output logic [4:0]       key
);
   // one lookup table; 0103 and gaps stay unassigned
   always_comb begin
      hit = 1'b1;
      key = KEY_DIGIT0;
      if (code <= 14'h0009) begin
         key = code[4:0];                                       // [RULE4]
      end else begin
         unique case (code)
            14'h0064: key = KEY_CLEAR;                          // [RULE5]
            14'h0065: key = KEY_SIGN;                           // [RULE5]
            14'h0066: key = KEY_DOT;                            // [RULE5]
            14'h0068: key = KEY_ENTER;                          // [RULE5]
            14'h006D: key = KEY_AXIS1;                          // [RULE6]
            14'h006E: key = 5'(KEY_AXIS1 + 5'h01);              // [RULE6]
            14'h006F: key = 5'(KEY_AXIS1 + 5'h02);              // [RULE6]
            14'h0072: key = KEY_SOFT1;                          // [RULE7]
            14'h0073: key = 5'(KEY_SOFT1 + 5'h01);              // [RULE7]
            14'h0074: key = 5'(KEY_SOFT1 + 5'h02);              // [RULE7]
            14'h0075: key = 5'(KEY_SOFT1 + 5'h03);              // [RULE7]
            14'h0087: key = KEY_LEFT;                           // [RULE8]
            14'h0088: key = KEY_RIGHT;                          // [RULE8]
            14'h0089: key = KEY_UP;                             // [RULE8]
            14'h008A: key = KEY_DOWN;                           // [RULE8]
            default:  hit = 1'b0;                               // [RULE16]
         endcase
      end
   end
endmodule : hrc_key_decode

// *** hrc_parser.sv ***
// Purpose: parse remote command frames arriving over the usb data interface
// Assumes: bytes come from same-clock logic, one per rx.valid cycle
// Notes:   command outputs are one-cycle pulses from flip-flops; lock is a level
//          frame assembly and command decode are two separate state groups
`timescale 1ns/100ps
// What this block does
// RULE1: escape, T, four digits, carriage return presses the addressed key.
// RULE2: escape, A, four digits, carriage return requests output to the host.
// RULE3: escape, S, four digits, carriage return is a special-function request.
// RULE4: key codes 0000 to 0009 press the matching numeric key.
// RULE5: 0100 clear, 0101 sign change, 0102 decimal point, 0104 enter; 0103 nothing.
// RULE6: 0109, 0110, 0111 press axis keys one, two and three.
// RULE7: 0114 to 0117 press soft keys one to four in order.
// RULE8: 0135 to 0138 press left, right, up and down arrows.
// RULE9: output code 0000 sends identification.
// RULE10: output code 0200 sends the actual axis positions.
// RULE11: special code 0000 resets the device.
// RULE12: special 0001 locks the local keypad and 0002 releases it.
// RULE13: a bare Ctrl-B sends the current position, a bare Ctrl-P a screen capture.
// RULE14: commands and replies travel only over the usb data interface.
// RULE15: escape is 0x1B, carriage return 0x0D, Ctrl-B 0x02, Ctrl-P 0x10.
// RULE16: a malformed or unknown frame is dropped with no effect and parsing waits for escape.
// RULE17: an escape byte restarts frame assembly at any point.
module hrc_parser
   import hrc_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rstn,
   input  wire hrc_pkg::hrc_byte_t rx,
   input  wire logic            local_key_valid,
   input  wire logic [4:0]      local_key_code,
   output hrc_pkg::hrc_cmd_t    cmd,
   output logic                 keypad_locked,
   output logic                 key_out_valid,
   output logic [4:0]           key_out_code
);
   import hrc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_CLASS = 4'b0010,
      ST_DIGIT = 4'b0100,
      ST_CR    = 4'b1000
   } hrc_state_t;

   hrc_state_t  state_r, state_nxt;
   logic [7:0]  class_r, class_nxt;
   logic [13:0] code_r, code_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   hrc_cmd_t    cmd_r, cmd_nxt;
   logic        lock_r, lock_nxt;
   logic        key_hit;
   logic [4:0]  key_idx;
   logic        is_digit;
   logic [13:0] code_acc;
   // decode helpers shared by the frame and command groups
   logic        take_esc;
   logic        take_byte;
   logic        at_idle;
   logic        frame_end;
   logic        class_ok;
   logic        is_key;
   logic        is_out;
   logic        is_spc;
   logic        code_id;
   logic        code_pos;
   logic        code_reset;
   logic        code_lock;
   logic        code_unlock;
   logic        ctrl_pos;
   logic        ctrl_screen;

   hrc_key_decode u_key (
      .code (code_r),
      .hit  (key_hit),
      .key  (key_idx)
   );

   assign is_digit = (rx.data >= ASCII_ZERO) && (rx.data <= ASCII_NINE);
   // decimal accumulate; four digits at most fit 14 bits
   assign code_acc = 14'(code_r * 14'd10) + 14'(rx.data - ASCII_ZERO);

   // byte qualifiers; escape beats everything so a frame can always restart
   assign take_esc  = rx.valid && (rx.data == ESC_BYTE);          // [RULE15] [RULE17]
   assign take_byte = rx.valid && (rx.data != ESC_BYTE);
   assign at_idle   = (state_r == ST_IDLE);
   // a frame ends only on carriage return in the closing slot
   assign frame_end = take_byte && (state_r == ST_CR) && (rx.data == CR_BYTE); // [RULE16]

   // class letters, held one for the frame and one for the byte in flight
   assign is_key    = (class_r == CLASS_KEY);                     // [RULE1]
   assign is_out    = (class_r == CLASS_OUT);                     // [RULE2]
   assign is_spc    = (class_r == CLASS_SPC);                     // [RULE3]
   assign class_ok  = (rx.data == CLASS_KEY) || (rx.data == CLASS_OUT) ||
                      (rx.data == CLASS_SPC);                     // [RULE1] [RULE2] [RULE3]

   // fixed command codes for the output and special classes
   assign code_id     = (code_r == CODE_ID);                      // [RULE9]
   assign code_pos    = (code_r == CODE_POS);                     // [RULE10]
   assign code_reset  = (code_r == CODE_RESET);                   // [RULE11]
   assign code_lock   = (code_r == CODE_LOCK);                    // [RULE12]
   assign code_unlock = (code_r == CODE_UNLOCK);                  // [RULE12]

   // bare control characters; inside a frame they are just bad bytes
   assign ctrl_pos    = take_byte && at_idle && (rx.data == CTRL_B); // [RULE13] [RULE15]
   assign ctrl_screen = take_byte && at_idle && (rx.data == CTRL_P); // [RULE13] [RULE15]

   // frame assembly: escape, class, four digits, closing byte
   always_comb begin
      state_nxt = state_r;
      class_nxt = class_r;
      code_nxt  = code_r;
      cnt_nxt   = cnt_r;
      if (take_esc) begin
         state_nxt = ST_CLASS;                                    // [RULE17]
         code_nxt  = '0;
         cnt_nxt   = '0;
      end else if (take_byte) begin
         unique case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;                         // stray bytes wait for escape
            ST_CLASS: begin
               class_nxt = rx.data;
               state_nxt = class_ok ? ST_DIGIT : ST_IDLE;         // [RULE16]
            end
            ST_DIGIT: begin
               if (is_digit) begin
                  code_nxt = code_acc;
                  cnt_nxt  = 2'(cnt_r + 2'd1);
                  if (cnt_r == 2'(CODE_DIGITS - 1)) state_nxt = ST_CR;
               end else begin
                  state_nxt = ST_IDLE;                            // [RULE16]
               end
            end
            ST_CR: state_nxt = ST_IDLE;                           // closing byte ends every frame
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   // frame registers; a stale code cannot leak because escape clears it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         class_r <= 8'h00;
         code_r  <= 14'h0000;
         cnt_r   <= 2'h0;
      end else begin
         state_r <= state_nxt;
         class_r <= class_nxt;
         code_r  <= code_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // command decode; every command is a one-cycle pulse, the lock a level
   always_comb begin
      cmd_nxt  = '0;
      lock_nxt = lock_r;
      cmd_nxt.send_position = ctrl_pos;                           // [RULE13]
      cmd_nxt.send_screen   = ctrl_screen;                        // [RULE13]
      if (frame_end) begin
         if (is_key && key_hit) begin
            cmd_nxt.key_press = 1'b1;                             // [RULE1]
            cmd_nxt.key_code  = key_idx;                          // decoded key index
         end
         if (is_out) begin
            cmd_nxt.send_ident    = code_id;                      // [RULE9] [RULE2]
            cmd_nxt.send_position = code_pos;                     // [RULE10]
         end
         if (is_spc) begin
            cmd_nxt.device_reset = code_reset;                    // [RULE11] [RULE3]
            if (code_lock)   lock_nxt = 1'b1;                     // [RULE12]
            if (code_unlock) lock_nxt = 1'b0;                     // [RULE12]
         end
         // any other code falls through with no effect [RULE16]
      end
   end

   // command and lock registers; the lock holds until reset or a release frame
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmd_r  <= '0;
         lock_r <= 1'b0;
      end else begin
         cmd_r  <= cmd_nxt;
         lock_r <= lock_nxt;
      end
   end

   // keypad merge: remote presses always pass, local ones only while unlocked
   logic       kv_nxt, kv_r;
   logic [4:0] kc_nxt, kc_r;
   always_comb begin
      kv_nxt = 1'b0;
      kc_nxt = kc_r;
      if (cmd_r.key_press) begin                              // [RULE1]
         kv_nxt = 1'b1;
         kc_nxt = cmd_r.key_code;
      end else if (local_key_valid && !lock_r) begin          // [RULE12]
         kv_nxt = 1'b1;
         kc_nxt = local_key_code;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         kv_r <= 1'b0;
         kc_r <= 5'h00;
      end else begin
         kv_r <= kv_nxt;
         kc_r <= kc_nxt;
      end
   end

   assign cmd           = cmd_r;   // replies go back over the usb path [RULE14]
   assign keypad_locked = lock_r;
   assign key_out_valid = kv_r;
   assign key_out_code  = kc_r;
endmodule : hrc_parser

// *** hrc_parser_properties.sv ***
// Purpose: port timing checks for the command parser
// Assumes: one clock, asynchronous active-low reset
// Notes:   every cmd pulse except device_reset is tied to the byte taken one edge earlier; device_reset is only checked for not repeating
`timescale 1ns/100ps
module hrc_chk
(
   input wire logic              clk_sys,
   input wire logic              rstn,
   input wire hrc_pkg::hrc_byte_t rx,
   input wire logic              local_key_valid,
   input wire logic [4:0]        local_key_code,
   input wire hrc_pkg::hrc_cmd_t cmd,
   input wire logic              keypad_locked,
   input wire logic              key_out_valid,
   input wire logic [4:0]        key_out_code
);
   import hrc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_key_follow: assert property (cmd.key_press |=> key_out_valid
      && key_out_code == $past(cmd.key_code)) else $error("remote key not forwarded");
   a_key_after_cr: assert property (cmd.key_press |-> $past(rx.valid)
      && $past(rx.data) == CR_BYTE) else $error("key press without carriage return");
   a_code_idle: assert property (!cmd.key_press |-> cmd.key_code == 5'h00)
      else $error("key code not cleared");
   a_ident_cause: assert property (cmd.send_ident |-> $past(rx.valid)
      && $past(rx.data) == CR_BYTE) else $error("ident without frame end");
   a_pos_cause: assert property (cmd.send_position |-> $past(rx.valid)
      && ($past(rx.data) == CR_BYTE || $past(rx.data) == CTRL_B)) else $error("bad position");
   a_screen_cause: assert property (cmd.send_screen |-> $past(rx.valid)
      && $past(rx.data) == CTRL_P) else $error("screen capture without request");
   a_reset_one: assert property (cmd.device_reset |=> (!cmd.device_reset)[*5])
      else $error("device reset repeated");
   a_lock_change: assert property ($changed(keypad_locked) |-> $past(rx.valid)
      && $past(rx.data) == CR_BYTE) else $error("lock moved without frame");
   a_lock_drop: assert property (local_key_valid && keypad_locked && !cmd.key_press
      |=> !key_out_valid) else $error("local key passed while locked");
   a_local_pass: assert property (local_key_valid && !keypad_locked && !cmd.key_press
      |=> key_out_valid && key_out_code == $past(local_key_code)) else $error("local key lost");
endmodule : hrc_chk
bind hrc_parser hrc_chk u_hrc_chk (.clk_sys(clk_sys), .rstn(rstn), .rx(rx),
   .local_key_valid(local_key_valid), .local_key_code(local_key_code), .cmd(cmd),
   .keypad_locked(keypad_locked), .key_out_valid(key_out_valid), .key_out_code(key_out_code));

// *** hrc_host_model.sv ***
// Purpose: host application sending command bytes
// Assumes: bytes change at the falling clock edge
// Notes:   released data shows the inverse byte so stale data never matches
`timescale 1ns/100ps
module hrc_host_model
(
   input  wire logic         clk_sys,
   output hrc_pkg::hrc_byte_t rx
);
   import hrc_pkg::*;
   initial rx = '0;
   // one byte per strobe, then the line is released
   task automatic send(input logic [7:0] b);
      @(negedge clk_sys);
      rx <= '{valid: 1'b1, data: b};
      @(negedge clk_sys);
      rx <= '{valid: 1'b0, data: ~b};
   endtask : send
   // escape, class, four digits most significant first, then the closing byte
   task automatic frame(input logic [7:0] cls, input logic [15:0] code,
                        input logic [7:0] last);
      send(ESC_BYTE);
      send(cls);
      for (int i = 3; i >= 0; i--) send(ASCII_ZERO + {4'h0, code[i*4 +: 4]});
      send(last);
   endtask : frame
endmodule : hrc_host_model

// *** test_host_remote_command_parser.sv ***
// Purpose: self-checking bench for the command parser
// Assumes: pulses are gathered over a short window after each frame
// Notes:   row = class, code, kind (0 key 1 ident 2 position 3 reset 4 none 5 screen), key
`timescale 1ns/100ps
module test_host_remote_command_parser;
   import hrc_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fails++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
   logic       clk_sys = 1'b0;
   logic       rstn;
   logic       local_key_valid;
   logic [4:0] local_key_code, key_out_code, ko_code;
   logic       keypad_locked, key_out_valid;
   hrc_byte_t  rx;
   hrc_cmd_t   cmd, acc;
   int         fails, n_tests, ko_n;
   localparam logic [31:0] ROWS [34] = '{32'h54000000, 32'h54000101, 32'h54000202,
      32'h54000303, 32'h54000404, 32'h54000505, 32'h54000606, 32'h54000707, 32'h54000808,
      32'h54000909, 32'h5401000A, 32'h5401010B, 32'h5401020C, 32'h5401040D, 32'h5401090E,
      32'h5401100F, 32'h54011110, 32'h54011411, 32'h54011512, 32'h54011613, 32'h54011714,
      32'h54013515, 32'h54013616, 32'h54013717, 32'h54013818, 32'h41000020, 32'h41020040,
      32'h53000060, 32'h54010380, 32'h58000080, 32'h53000380, 32'h41010080, 32'h54010A80,
      32'h54999980};
   always #20 clk_sys = ~clk_sys;
   hrc_host_model u_hrc_host_model (.clk_sys(clk_sys), .rx(rx));
   hrc_parser u_hrc_parser (.clk_sys(clk_sys), .rstn(rstn), .rx(rx),
      .local_key_valid(local_key_valid), .local_key_code(local_key_code), .cmd(cmd),
      .keypad_locked(keypad_locked), .key_out_valid(key_out_valid), .key_out_code(key_out_code));
   // gather pulses so one check covers a whole frame
   always @(posedge clk_sys) begin
      acc <= acc | cmd;
      if (key_out_valid === 1'b1) begin
         ko_n <= ko_n + 1;
         ko_code <= key_out_code;
      end
   end
   function automatic hrc_cmd_t want(input logic [7:0] e);
      want = '0;
      want.key_press = (e[7:5] == 3'd0);
      want.key_code = want.key_press ? e[4:0] : 5'h00;
      want.send_ident = (e[7:5] == 3'd1);
      want.send_position = (e[7:5] == 3'd2);
      want.device_reset = (e[7:5] == 3'd3);
      want.send_screen = (e[7:5] == 3'd5);
   endfunction : want
   task automatic check(input hrc_cmd_t e, input int ko, input logic [4:0] k);
      repeat (4) @(negedge clk_sys);
      `CHK("cmd", e, acc)
      `CHK("key_out count", ko, ko_n)
      if (ko > 0) `CHK("key_out_code", k, ko_code)
      acc = '0;
      ko_n = 0;
   endtask : check
   task automatic local_press(input logic [4:0] k);
      @(negedge clk_sys);
      local_key_valid = 1'b1;
      local_key_code = k;
      @(negedge clk_sys);
      local_key_valid = 1'b0;
   endtask : local_press
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // a hang is cut short well past the expected run length
   initial begin
      #(40 * 20000);
      fails++;
      give_verdict();
   end
   initial begin
      {rstn, local_key_valid, local_key_code, acc, ko_n, fails, n_tests} = '0;
      repeat (6) @(negedge clk_sys);
      `CHK("reset outputs", '0, {cmd, keypad_locked, key_out_valid, key_out_code})
      rstn = 1'b1;
      foreach (ROWS[i]) begin
         u_hrc_host_model.frame(ROWS[i][31:24], ROWS[i][23:8], CR_BYTE);
         check(want(ROWS[i][7:0]), int'(ROWS[i][7:5] == 3'd0), ROWS[i][4:0]);
      end
      // bare control bytes, then a restart and two broken frame ends
      u_hrc_host_model.send(CTRL_B);
      check(want(8'h40), 0, 5'h00);
      u_hrc_host_model.send(CTRL_P);
      check(want(8'hA0), 0, 5'h00);
      u_hrc_host_model.send(ESC_BYTE);
      u_hrc_host_model.send(CLASS_KEY);
      u_hrc_host_model.frame(CLASS_KEY, 16'h0104, CR_BYTE);
      check(want(8'h0D), 1, KEY_ENTER);
      u_hrc_host_model.frame(CLASS_KEY, 16'h0104, 8'h58);
      check('0, 0, 5'h00);
      u_hrc_host_model.frame(CLASS_KEY, 16'h0104, CTRL_B);
      check('0, 0, 5'h00);
      // locked keypad drops local keys but remote presses still land
      u_hrc_host_model.frame(CLASS_SPC, 16'h0001, CR_BYTE);
      check('0, 0, 5'h00);
      `CHK("locked", 1'b1, keypad_locked)
      local_press(5'h03);
      check('0, 0, 5'h00);
      u_hrc_host_model.frame(CLASS_KEY, 16'h0005, CR_BYTE);
      check(want(8'h05), 1, 5'h05);
      u_hrc_host_model.frame(CLASS_SPC, 16'h0002, CR_BYTE);
      check('0, 0, 5'h00);
      local_press(5'h07);
      check('0, 1, 5'h07);
      // a reset in mid-run clears the lock
      u_hrc_host_model.frame(CLASS_SPC, 16'h0001, CR_BYTE);
      check('0, 0, 5'h00);
      rstn = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK("lock after reset", 1'b0, keypad_locked)
      `CHK("cmd in reset", '0, {cmd, key_out_valid})
      rstn = 1'b1;
      // parsing and local keys resume cleanly after the release
      u_hrc_host_model.frame(CLASS_KEY, 16'h0002, CR_BYTE);
      check(want(8'h02), 1, 5'h02);
      local_press(5'h09);
      check('0, 1, 5'h09);
      give_verdict();
   end
endmodule : test_host_remote_command_parser
